/* design/rat_alarm_trim.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rat_defines.svh"

module rat_alarm_trim #(
   parameter int unsigned PULSE_CYCLES = `RAT_PULSE_MS * `RAT_CLK_KHZ,
   parameter int unsigned OSC_PER_SEC  = `RAT_OSC_PER_SEC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // APB slave
   input  wire rat_pkg::rat_apb_req_t apb_req,
   output var  rat_pkg::rat_apb_rsp_t apb_rsp,
   // Clock counters, same clock
   input  wire rat_pkg::rat_time_t    time_now,
   input  wire logic                  time_step,
   // Pins from the analog side
   input  wire logic                  osc_pulse_pin,
   input  wire logic                  on_battery_pin,
   // Oscillator trim and time base
   output logic [6:0]                 cap_half_pf,
   output logic                       second_tick,
   // Interrupt pin
   output logic                       irq_n,
   output logic                       alarm_pin_owned
);
   import rat_pkg::*;

   localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);
   localparam int unsigned SW = $clog2(OSC_PER_SEC + 1);

   // Registers
   logic [7:0]  ctrl_r;
   logic [7:0]  load_trim_r;
   logic [7:0]  rate_trim_r;
   logic [7:0]  match_r [6];
   logic        auto_clr_r;
   logic        alarm_flag_r;
   logic        single_done_r;
   logic [PW-1:0] pulse_cnt_r;
   logic [SW-1:0] presc_r;
   logic [20:0] accum_r;
   logic        osc_s1_r, osc_s2_r, osc_s3_r;
   logic        bat_s1_r, bat_s2_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic [6:0]  cap_r;
   logic        sec_r;
   logic        irq_n_r;
   logic        owned_r;

   // Decoded controls
   rat_mode_t   mode;
   logic        wr_acc, rd_acc, setup_acc;
   logic        match_hit;
   logic        alarm_set;
   logic [5:0]  byte_eq;
   logic [7:0]  time_bytes [6];
   logic [6:0]  ppm_mag;
   logic        corr_now;
   logic [20:0] accum_sum;
   logic [31:0] rd_data;
   logic        rd_hit;

   // Capacitor value in half-pF units for a six-bit code
   function automatic logic [6:0] cap_of(input logic [5:0] code);
      cap_of = `RAT_CAP_BASE_HALF + (code[5] ? 7'h00 : `RAT_CAP_B5_HALF)
               + {2'b00, code[4:0]};
   endfunction : cap_of

   // Battery delta in half-pF units, two's complement
   function automatic logic [6:0] bat_delta(input logic [1:0] code);
      unique case (code)
         2'b00: bat_delta = `RAT_BAT_D00;
         2'b01: bat_delta = `RAT_BAT_D01;
         2'b10: bat_delta = `RAT_BAT_D10;
         2'b11: bat_delta = `RAT_BAT_D11;
      endcase
   endfunction : bat_delta

   // Match byte compare, disabled bytes always agree
   function automatic logic byte_match(input logic [7:0] m, input logic [7:0] t);
      byte_match = !m[`RAT_MB_ENABLE] || (m[6:0] == t[6:0]);
   endfunction : byte_match

   // APB phases: answer one cycle into the access phase
   assign setup_acc = apb_req.psel && apb_req.penable && !pready_r;
   assign wr_acc    = apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite;
   assign rd_acc    = apb_req.psel && apb_req.penable && pready_r && !apb_req.pwrite;

   // Mode select from control bits
   always_comb begin
      if (!ctrl_r[`RAT_CT_ALARM_ON] || (ctrl_r[`RAT_CT_FO_HI:`RAT_CT_FO_LO] != 4'h0)) begin
         mode = RAT_MODE_OFF;
      end else if (ctrl_r[`RAT_CT_REPEAT]) begin
         mode = RAT_MODE_REPEAT;
      end else begin
         mode = RAT_MODE_SINGLE;
      end
   end

   // Time bytes in match register order; the year is not an input at all
   assign time_bytes[0] = time_now.seconds;
   assign time_bytes[1] = time_now.minutes;
   assign time_bytes[2] = time_now.hours;
   assign time_bytes[3] = time_now.date;
   assign time_bytes[4] = time_now.month;
   assign time_bytes[5] = time_now.weekday;

   // Compare every byte against its counter
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         byte_eq[i] = byte_match(match_r[i], time_bytes[i]);
      end
   end

   // Alarm fires only on the step into a matching time
   assign match_hit = time_step && (&byte_eq);
   always_comb begin
      unique case (mode)
         RAT_MODE_OFF:    alarm_set = 1'b0;
         RAT_MODE_SINGLE: alarm_set = match_hit && !single_done_r;
         RAT_MODE_REPEAT: alarm_set = match_hit;
      endcase
   end

   // Control register, alarm mode and frequency select
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_r <= `RAT_RST_BYTE;
      end else if (wr_acc && apb_req.paddr == `RAT_ADDR_CONTROL) begin
         ctrl_r <= apb_req.pwdata[7:0];
      end
   end

   // Trim registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         load_trim_r <= `RAT_RST_BYTE;
         rate_trim_r <= `RAT_RST_BYTE;
      end else if (wr_acc) begin
         if (apb_req.paddr == `RAT_ADDR_LOAD_TRIM) begin
            load_trim_r <= apb_req.pwdata[7:0];
         end
         if (apb_req.paddr == `RAT_ADDR_RATE_TRIM) begin
            rate_trim_r <= {5'h00, apb_req.pwdata[2:0]};
         end
      end
   end

   // Alarm match bytes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 6; i++) begin
            match_r[i] <= `RAT_RST_BYTE;
         end
      end else if (wr_acc) begin
         for (int i = 0; i < 6; i++) begin
            if (apb_req.paddr == `RAT_ADDR_SEC_MATCH + 8'(4 * i)) begin
               match_r[i] <= apb_req.pwdata[7:0];
            end
         end
      end
   end

   // Auto-clear enable in the status register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         auto_clr_r <= 1'b0;
      end else if (wr_acc && apb_req.paddr == `RAT_ADDR_STATUS) begin
         auto_clr_r <= apb_req.pwdata[`RAT_ST_AUTO_CLR];
      end
   end

   // Alarm flag: a set always beats a clear in the same cycle.
   // Auto-clear only drops a flag that the read actually returned, so an
   // alarm that lands between data capture and completion is not lost.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         alarm_flag_r <= 1'b0;
      end else if (alarm_set) begin
         alarm_flag_r <= 1'b1;
      end else if (wr_acc && apb_req.paddr == `RAT_ADDR_STATUS
                   && !apb_req.pwdata[`RAT_ST_ALARM_FLAG]) begin
         alarm_flag_r <= 1'b0;
      end else if (rd_acc && auto_clr_r && prdata_r[`RAT_ST_ALARM_FLAG]
                   && apb_req.paddr == `RAT_ADDR_STATUS) begin
         alarm_flag_r <= 1'b0;
      end
   end

   // One-time latch for single-event mode, rearmed by a control write
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         single_done_r <= 1'b0;
      end else if (wr_acc && apb_req.paddr == `RAT_ADDR_CONTROL) begin
         single_done_r <= 1'b0;
      end else if (alarm_set && mode == RAT_MODE_SINGLE) begin
         single_done_r <= 1'b1;
      end
   end

   // Repeat-mode pulse timer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulse_cnt_r <= '0;
      end else if (mode != RAT_MODE_REPEAT) begin
         pulse_cnt_r <= '0;
      end else if (alarm_set) begin
         pulse_cnt_r <= PW'(PULSE_CYCLES);
      end else if (pulse_cnt_r != '0) begin
         pulse_cnt_r <= pulse_cnt_r - PW'(1);
      end
   end

   // Interrupt pin, high when idle or owned by the frequency output
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_n_r <= 1'b1;
         owned_r <= 1'b1;
      end else begin
         owned_r <= (ctrl_r[`RAT_CT_FO_HI:`RAT_CT_FO_LO] == 4'h0);
         unique case (mode)
            RAT_MODE_OFF:    irq_n_r <= 1'b1;
            RAT_MODE_SINGLE: irq_n_r <= !(alarm_flag_r || alarm_set);
            RAT_MODE_REPEAT: irq_n_r <= !(alarm_set || pulse_cnt_r > PW'(1));
         endcase
      end
   end

   // Pin synchronisers
   // The third oscillator stage only serves the rising-edge detect
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
         bat_s1_r <= 1'b0;
         bat_s2_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_pulse_pin;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
         bat_s1_r <= on_battery_pin;
         bat_s2_r <= bat_s1_r;
      end
   end

   // Capacitor code, with the battery delta while on backup supply
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cap_r <= cap_of(6'h00);
      end else begin
         cap_r <= cap_of(load_trim_r[`RAT_LT_CODE_HI:`RAT_LT_CODE_LO])
                  + (bat_s2_r ? bat_delta(load_trim_r[`RAT_LT_BAT_HI:`RAT_LT_BAT_LO])
                              : 7'h00);
      end
   end

   // Rate trim magnitude; the sign only picks add or skip
   assign ppm_mag = (rate_trim_r[`RAT_RT_MAG_HI] ? 7'(`RAT_PPM_MSB) : 7'h00)
                  + (rate_trim_r[`RAT_RT_MAG_LO] ? 7'(`RAT_PPM_LSB) : 7'h00);
   assign accum_sum = accum_r + {14'h0000, ppm_mag};
   assign corr_now  = osc_s2_r && !osc_s3_r && (accum_sum >= 21'(`RAT_PPM_SCALE));

   // Correction accumulator spreads single-count steps evenly
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         accum_r <= '0;
      end else if (osc_s2_r && !osc_s3_r) begin
         if (corr_now) begin
            accum_r <= accum_sum - 21'(`RAT_PPM_SCALE);
         end else begin
            accum_r <= accum_sum;
         end
      end
   end

   // Second prescaler: positive trim counts two, negative counts none
   // A skipped count holds the prescaler; an added one advances it by two
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         presc_r <= '0;
         sec_r   <= 1'b0;
      end else begin
         sec_r <= 1'b0;
         if (osc_s2_r && !osc_s3_r) begin
            if (corr_now && rate_trim_r[`RAT_RT_SIGN]) begin
               presc_r <= presc_r;
            end else if (presc_r + SW'(corr_now ? 2 : 1) >= SW'(OSC_PER_SEC)) begin
               presc_r <= presc_r + SW'(corr_now ? 2 : 1) - SW'(OSC_PER_SEC);
               sec_r   <= 1'b1;
            end else begin
               presc_r <= presc_r + SW'(corr_now ? 2 : 1);
            end
         end
      end
   end

   // Read data mux
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (apb_req.paddr)
         `RAT_ADDR_STATUS: begin
            rd_data[`RAT_ST_AUTO_CLR]   = auto_clr_r;
            rd_data[`RAT_ST_ALARM_FLAG] = alarm_flag_r;
         end
         `RAT_ADDR_CONTROL:     rd_data[7:0] = ctrl_r;
         `RAT_ADDR_LOAD_TRIM:   rd_data[7:0] = load_trim_r;
         `RAT_ADDR_RATE_TRIM:   rd_data[7:0] = rate_trim_r;
         `RAT_ADDR_SEC_MATCH:   rd_data[7:0] = match_r[0];
         `RAT_ADDR_MIN_MATCH:   rd_data[7:0] = match_r[1];
         `RAT_ADDR_HOUR_MATCH:  rd_data[7:0] = match_r[2];
         `RAT_ADDR_DATE_MATCH:  rd_data[7:0] = match_r[3];
         `RAT_ADDR_MONTH_MATCH: rd_data[7:0] = match_r[4];
         `RAT_ADDR_WDAY_MATCH:  rd_data[7:0] = match_r[5];
         `RAT_ADDR_CAP_STATE:   rd_data[6:0] = cap_r;
         default:               rd_hit = 1'b0;
      endcase
   end

   // APB answer registers; read data is latched on the first access edge
   // and stays put until the next read, as the bus contract promises
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup_acc;
         pslverr_r <= setup_acc && !rd_hit;
         if (setup_acc && !apb_req.pwrite) begin
            prdata_r <= rd_data;
         end
      end
   end

   // Outputs
   assign apb_rsp         = '{pready:  pready_r,
                              pslverr: pslverr_r,
                              prdata:  prdata_r};
   assign cap_half_pf     = cap_r;
   assign second_tick     = sec_r;
   assign irq_n           = irq_n_r;
   assign alarm_pin_owned = owned_r;

endmodule : rat_alarm_trim
`default_nettype wire

/* inc/rat_defines.svh */
`ifndef RAT_DEFINES_SVH
`define RAT_DEFINES_SVH

// Register byte addresses on the APB side
`define RAT_ADDR_STATUS      8'h00
`define RAT_ADDR_CONTROL     8'h04
`define RAT_ADDR_LOAD_TRIM   8'h08
`define RAT_ADDR_RATE_TRIM   8'h0C
`define RAT_ADDR_SEC_MATCH   8'h10
`define RAT_ADDR_MIN_MATCH   8'h14
`define RAT_ADDR_HOUR_MATCH  8'h18
`define RAT_ADDR_DATE_MATCH  8'h1C
`define RAT_ADDR_MONTH_MATCH 8'h20
`define RAT_ADDR_WDAY_MATCH  8'h24
`define RAT_ADDR_CAP_STATE   8'h28

// Status register fields
`define RAT_ST_AUTO_CLR      7
`define RAT_ST_ALARM_FLAG    2
// Control register fields
`define RAT_CT_REPEAT        7
`define RAT_CT_ALARM_ON      6
`define RAT_CT_FO_HI         3
`define RAT_CT_FO_LO         0
// Crystal load trim fields
`define RAT_LT_BAT_HI        7
`define RAT_LT_BAT_LO        6
`define RAT_LT_CODE_HI       5
`define RAT_LT_CODE_LO       0
// Rate trim fields
`define RAT_RT_SIGN          2
`define RAT_RT_MAG_HI        1
`define RAT_RT_MAG_LO        0
// Match byte enable bit
`define RAT_MB_ENABLE        7

// Reset values
`define RAT_RST_BYTE         8'h00

// Capacitance in half-picofarad units
`define RAT_CAP_BASE_HALF    7'h12
`define RAT_CAP_B5_HALF      7'h20
// Battery deltas in half-picofarad units
`define RAT_BAT_D00          7'h00
`define RAT_BAT_D01          7'h7F
`define RAT_BAT_D10          7'h01
`define RAT_BAT_D11          7'h02

// Rate trim weights in ppm
`define RAT_PPM_LSB          20
`define RAT_PPM_MSB          40
`define RAT_PPM_SCALE        1000000

// Oscillator counts per second
`define RAT_OSC_PER_SEC      32768

// Timing
`define RAT_CLK_KHZ          25000
`define RAT_PULSE_MS         250

`endif

/* inc/rat_pkg.sv */
package rat_pkg;

   // Alarm operating mode
   typedef enum logic [1:0] {
      RAT_MODE_OFF    = 2'b00,
      RAT_MODE_SINGLE = 2'b01,
      RAT_MODE_REPEAT = 2'b10
   } rat_mode_t;

   // Current clock counter values, BCD bytes
   typedef struct packed {
      logic [7:0] weekday;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } rat_time_t;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rat_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } rat_apb_rsp_t;

endpackage : rat_pkg

/* verification/rat_alarm_trim_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module rat_alarm_trim_monitor #(
   parameter int unsigned PULSE_CYCLES = 20,
   parameter int unsigned OSC_PER_SEC  = 16
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  reset_n,
   // Register bus
   input wire rat_pkg::rat_apb_req_t apb_req,
   input wire rat_pkg::rat_apb_rsp_t apb_rsp,
   // Counters and pins
   input wire rat_pkg::rat_time_t    time_now,
   input wire logic                  time_step,
   input wire logic                  osc_pulse_pin,
   input wire logic                  on_battery_pin,
   // Outputs
   input wire logic [6:0]            cap_half_pf,
   input wire logic                  second_tick,
   input wire logic                  irq_n,
   input wire logic                  alarm_pin_owned
);
   import rat_pkg::*;

   // One clock domain for every check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Bus answer timing, error and read data
   a_ready_one_wait: assert property (
      $rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (
      apb_rsp.pready && apb_req.paddr[1:0] == 2'h0
      |-> apb_rsp.pslverr == (apb_req.paddr > 8'h28))
      else $error("pslverr wrong for address");
   a_rdata_upper: assert property (
      apb_rsp.pready && !apb_req.pwrite |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("read data upper bits set");

   // Alarm pin falls only after a counter step while owned
   a_irq_cause: assert property (
      $fell(irq_n) |-> $past(time_step) && $past(alarm_pin_owned))
      else $error("irq fell without a time step");
   a_irq_quiet: assert property (
      !alarm_pin_owned && !$past(alarm_pin_owned) |-> irq_n)
      else $error("irq low while frequency output selected");

   // Trim outputs
   a_cap_range: assert property (
      cap_half_pf inside {[7'h11:7'h53]})
      else $error("capacitance code out of range");
   a_tick_pulse: assert property (
      second_tick |=> !second_tick)
      else $error("second tick longer than one cycle");
endmodule : rat_alarm_trim_monitor

bind rat_alarm_trim rat_alarm_trim_monitor #(
   .PULSE_CYCLES(PULSE_CYCLES),
   .OSC_PER_SEC (OSC_PER_SEC)
) u_monitor (
   .clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .time_now(time_now), .time_step(time_step), .osc_pulse_pin(osc_pulse_pin),
   .on_battery_pin(on_battery_pin), .cap_half_pf(cap_half_pf),
   .second_tick(second_tick), .irq_n(irq_n), .alarm_pin_owned(alarm_pin_owned));
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rat_defines.svh"
module tb;
   import rat_pkg::*;
   localparam int unsigned PULSE = 20;
   localparam int unsigned OSC   = 16;
   localparam logic [7:0]  ST    = `RAT_ADDR_STATUS;
   localparam logic [7:0]  CT    = `RAT_ADDR_CONTROL;
   localparam logic [7:0]  LT    = `RAT_ADDR_LOAD_TRIM;
   localparam logic [7:0]  RT    = `RAT_ADDR_RATE_TRIM;
   localparam logic [7:0]  MA    = `RAT_ADDR_SEC_MATCH;
   localparam logic [7:0]  CP    = `RAT_ADDR_CAP_STATE;
   localparam logic [7:0]  AL [6] = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00};
   logic         clk;
   logic         reset_n;
   rat_apb_req_t apb_req;
   rat_apb_rsp_t apb_rsp;
   rat_time_t    time_now;
   logic         time_step;
   logic         osc_pulse_pin;
   logic         on_battery_pin;
   logic [6:0]   cap_half_pf;
   logic         second_tick;
   logic         irq_n;
   logic         alarm_pin_owned;
   logic [2:0]   osc_div;
   logic [31:0]  rd;
   logic         er;
   int           err_total;
   int           check_count;

   // Block under test with short counts
   rat_alarm_trim #(.PULSE_CYCLES(PULSE), .OSC_PER_SEC(OSC)) DUT (
      .clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .time_now(time_now), .time_step(time_step), .osc_pulse_pin(osc_pulse_pin),
      .on_battery_pin(on_battery_pin), .cap_half_pf(cap_half_pf),
      .second_tick(second_tick), .irq_n(irq_n), .alarm_pin_owned(alarm_pin_owned));

   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Oscillator pin, one rising edge every eight clocks
   always @(posedge clk) begin
      osc_div       <= osc_div + 3'h1;
      osc_pulse_pin <= osc_div[2];
   end

   // Expected per-pin capacitance in half picofarads
   function automatic logic [31:0] cap_exp(input logic [7:0] lt, input logic bat);
      int bd [4] = '{0, -1, 1, 2};
      return 32'(18 + (lt[5] ? 0 : 32) + int'(lt[4:0]) + (bat ? bd[lt[7:6]] : 0));
   endfunction : cap_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tdone(input string name);
      $display("test %s done, errors %0d", name, err_total);
   endtask : tdone

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // One bus transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 16);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      if (n >= 16) begin
         err_total++;
         conclude();
      end
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rdc

   // Present a new counter value with its step pulse
   task automatic step(input rat_time_t t);
      @(posedge clk);
      time_now  <= t;
      time_step <= 1'b1;
      @(posedge clk);
      time_step <= 1'b0;
      @(posedge clk);
   endtask : step

   initial begin
      int         n;
      logic [7:0] v;
      logic [7:0] a8;
      logic [5:0] en;
      logic       hit;
      rat_time_t  t;
      reset_n        = 1'b0;
      apb_req        = '0;
      time_now       = '0;
      time_step      = 1'b0;
      on_battery_pin = 1'b0;
      osc_div        = 3'h0;
      err_total      = 0;
      check_count    = 0;
      n              = $urandom(65);
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values and an unmapped place
      for (int a = 0; a < 10; a++) begin
         rdc(8'(4 * a), 32'h0);
      end
      rdc(CP, 32'h32);
      rdc(8'h2C, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 8'h2C, 8'hFF);
      chk({31'h0, er}, 32'h1);
      tdone("reset");
      // Random write and read back
      for (int i = 0; i < 14; i++) begin
         a8 = (i < 2) ? LT : MA + 8'(4 * (i % 6));
         v  = 8'($urandom);
         apb(1'b1, a8, v);
         rdc(a8, {24'h0, v});
      end
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, RT, 8'(i));
         rdc(RT, 32'(i));
      end
      // Every analog code and battery delta
      for (int c = 0; c < 64; c++) begin
         v = {2'(c), 6'(c * 37)};
         on_battery_pin <= 1'($urandom);
         apb(1'b1, LT, v);
         repeat (6) @(posedge clk);
         chk({25'h0, cap_half_pf}, cap_exp(v, on_battery_pin));
         rdc(CP, cap_exp(v, on_battery_pin));
      end
      tdone("trim");
      // Single event on a calendar match, counter bit 7 set
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, MA + 8'(4 * i), AL[i]);
      end
      apb(1'b1, CT, 8'h40);
      t = {8'($urandom), 8'h81, 8'h81, 8'h91, 8'h29, 8'($urandom)};
      step(t);
      chk({31'h0, irq_n}, 32'h1);
      t.minutes = 8'hB0;
      step(t);
      chk({31'h0, irq_n}, 32'h0);
      rdc(ST, 32'h04);
      apb(1'b1, ST, 8'h04);
      chk({31'h0, irq_n}, 32'h0);
      apb(1'b1, ST, 8'h00);
      repeat (2) @(posedge clk);
      chk({31'h0, irq_n}, 32'h1);
      apb(1'b1, ST, 8'h04);
      rdc(ST, 32'h0);
      step(t);
      chk({31'h0, irq_n}, 32'h1);
      tdone("single");
      // Random enable subsets, one enabled byte off when no hit
      for (int k = 0; k < 10; k++) begin
         en  = 6'($urandom) | 6'(1 << (k % 6));
         hit = 1'($urandom);
         t   = 48'({$urandom, $urandom});
         for (int i = 0; i < 6; i++) begin
            apb(1'b1, MA + 8'(4 * i), {en[i], t[8 * i +: 7]});
         end
         if (!hit) t[8 * (k % 6)] = ~t[8 * (k % 6)];
         apb(1'b1, ST, 8'h00);
         apb(1'b1, CT, 8'h40);
         step(t);
         chk({31'h0, irq_n}, {31'h0, !hit});
         rdc(ST, {29'h0, hit, 2'h0});
      end
      tdone("subset");
      // Repeating pulses on seconds only, auto clear on read
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, MA + 8'(4 * i), (i == 0) ? 8'hB0 : 8'h00);
      end
      apb(1'b1, ST, 8'h80);
      apb(1'b1, CT, 8'hC0);
      t.seconds = 8'h30;
      for (int p = 0; p < 2; p++) begin
         step(t);
         n = 0;
         while (irq_n === 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
         end
         chk(32'(n), 32'(PULSE));
      end
      rdc(ST, 32'h84);
      rdc(ST, 32'h80);
      // Alarm landing inside an auto-clear read survives it
      fork
         apb(1'b0, ST, 8'h00);
         begin
            @(posedge clk);
            step(t);
         end
      join
      chk(rd, 32'h80);
      rdc(ST, 32'h84);
      // Every frequency select keeps the alarm off
      for (int f = 1; f < 16; f++) begin
         apb(1'b1, CT, {4'hC, 4'(f)});
         repeat (3) @(posedge clk);
         chk({31'h0, alarm_pin_owned}, 32'h0);
         step(t);
         chk({31'h0, irq_n}, 32'h1);
      end
      rdc(ST, 32'h80);
      apb(1'b1, CT, 8'h00);
      repeat (3) @(posedge clk);
      chk({31'h0, alarm_pin_owned}, 32'h1);
      tdone("repeat");
      // Second period with no trim and with negative zero
      for (int r = 0; r < 2; r++) begin
         apb(1'b1, RT, r ? 8'h04 : 8'h00);
         for (int g = 0; g < 2; g++) begin
            n = 0;
            do begin
               @(posedge clk);
               n++;
            end while (second_tick !== 1'b1 && n < 400);
         end
         chk(32'(n), 32'(8 * OSC));
      end
      tdone("tick");
      conclude();
   end
endmodule : tb
`default_nettype wire
